// *** src/ldt_defines.vh ***
`ifndef LDT_DEFINES_VH
`define LDT_DEFINES_VH
// Frame layout
`define LDT_FRM_RW 15
`define LDT_FRM_ADDR_HI 14
`define LDT_FRM_ADDR_LO 9
`define LDT_FRM_PAR 8
// Register addresses (6-bit address field)
`define LDT_ADDR_CTRL 6'h06
`define LDT_ADDR_AFTER_RUN 6'h07
`define LDT_ADDR_WAKE 6'h08
// Control field positions
`define LDT_BIT_FUNC_HI 7
`define LDT_BIT_FUNC_LO 5
`define LDT_BIT_READBACK 4
`define LDT_BIT_ACTIVE 3
`define LDT_BIT_RANGE 2
`define LDT_BIT_RUN 1
`define LDT_BIT_FLAG 0
// Reset values
`define LDT_RST_FUNC 3'h0
`define LDT_RST_BYTE 8'h00
// Function codes
`define LDT_FN_FLAG 3'h0
`define LDT_FN_OFF 3'h1
`define LDT_FN_OFF_WAKE 3'h2
`define LDT_FN_WAKE 3'h3
`define LDT_FN_SILENT 3'h4
// Timing
`define LDT_CLK_MHZ 125
`define LDT_CAL_STEP_US 488
`define LDT_SEC_STEP_US 1000000
`define LDT_CAL_CYCLES (`LDT_CAL_STEP_US * `LDT_CLK_MHZ)
`define LDT_SEC_CYCLES (`LDT_SEC_STEP_US * `LDT_CLK_MHZ)
`endif

// *** src/ldt_tick_gen.v ***
`include "ldt_defines.vh"
`default_nettype none
// Step tick divider: one-cycle pulse every calLen or secLen cycles
module ldt_tick_gen #(
  parameter CAL_LEN = `LDT_CAL_CYCLES,
  parameter SEC_LEN = `LDT_SEC_CYCLES
) (
  input wire clk_sys,
  input wire rst,
  input wire run,
  input wire rangeSec,
  output reg tick
);
  reg [31:0] cnt_ff;
  wire [31:0] lastCount;

  // Range picks the step length
  assign lastCount = rangeSec ? SEC_LEN - 1 : CAL_LEN - 1;

  // Divider holds at zero while stopped so each start gives full step
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_ff <= 32'h0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_ff <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_ff >= lastCount) begin
      cnt_ff <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** src/ldt_long_timer.v ***
`include "ldt_defines.vh"
`default_nettype none
module ldt_long_timer #(
  parameter CNT_W = 24,
  parameter CAL_LEN = `LDT_CAL_CYCLES,
  parameter SEC_LEN = `LDT_SEC_CYCLES
) (
  input wire clk_sys,
  input wire rst,
  input wire frameValid,
  input wire [15:0] frameIn,
  input wire inLowPowerOff,
  output reg [15:0] readData,
  output reg readValid,
  output reg parityErr,
  output reg timerIrq,
  output reg enterLowPowerOff,
  output reg wakeUp
);
  reg [2:0] func_ff;
  reg readback_ff;
  reg range_ff;
  reg run_ff;
  reg flag_ff;
  reg [CNT_W-1:0] afterRun_ff;
  reg [CNT_W-1:0] wakeVal_ff;
  reg [CNT_W-1:0] count_ff;
  reg afterDone_ff;
  wire tick;
  wire isWrite;
  wire [5:0] addr;
  wire [7:0] data;
  wire parityOk;
  wire active;
  wire countNow;
  wire [CNT_W-1:0] countInc;
  wire [CNT_W-1:0] wakeView;
  wire hitAfter;
  wire hitWake;

  // Odd parity over the whole frame including the parity bit
  function oddParity;
    input [15:0] f;
    begin
      oddParity = ^f;
    end
  endfunction

  // Byte lane insert for the wide value registers (index 0..2)
  function [CNT_W-1:0] putByte;
    input [CNT_W-1:0] old;
    input [7:0] b;
    input [1:0] lane;
    reg [CNT_W+7:0] tmp;
    begin
      tmp = {8'h00, old};
      tmp[lane*8 +: 8] = b;
      putByte = tmp[CNT_W-1:0];
    end
  endfunction

  // Frame decode
  assign isWrite = frameIn[`LDT_FRM_RW];
  assign addr = frameIn[`LDT_FRM_ADDR_HI:`LDT_FRM_ADDR_LO];
  assign data = frameIn[7:0];
  assign parityOk = oddParity(frameIn);

  ldt_tick_gen #(
    .CAL_LEN(CAL_LEN),
    .SEC_LEN(SEC_LEN)
  ) uTick (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(countNow),
    .rangeSec(range_ff),
    .tick(tick)
  );

  // Counting gate per function; unused codes never count
  assign countNow = run_ff && (
    (func_ff == `LDT_FN_FLAG && !inLowPowerOff && !afterDone_ff) ||
    (func_ff == `LDT_FN_OFF && !inLowPowerOff && !afterDone_ff) ||
    (func_ff == `LDT_FN_OFF_WAKE) ||
    ((func_ff == `LDT_FN_WAKE || func_ff == `LDT_FN_SILENT) && inLowPowerOff));
  assign active = countNow;
  assign countInc = count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
  assign hitAfter = tick && countInc == afterRun_ff;
  assign hitWake = tick && countInc == wakeVal_ff;
  // Readback view of the wake register
  assign wakeView = readback_ff ? count_ff : wakeVal_ff;

  // Register writes, counting and events
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      func_ff <= `LDT_RST_FUNC;
      readback_ff <= 1'b0;
      range_ff <= 1'b0;
      run_ff <= 1'b0;
      flag_ff <= 1'b0;
      afterRun_ff <= {CNT_W{1'b0}};
      wakeVal_ff <= {CNT_W{1'b0}};
      count_ff <= {CNT_W{1'b0}};
      afterDone_ff <= 1'b0;
      timerIrq <= 1'b0;
      enterLowPowerOff <= 1'b0;
      wakeUp <= 1'b0;
      parityErr <= 1'b0;
    end else begin
      timerIrq <= 1'b0;
      enterLowPowerOff <= 1'b0;
      wakeUp <= 1'b0;
      parityErr <= frameValid && isWrite && !parityOk;
      // Read of control clears flag; a same-cycle hit below wins
      if (frameValid && !isWrite && addr == `LDT_ADDR_CTRL)
        flag_ff <= 1'b0;
      if (frameValid && isWrite && parityOk) begin
        case (addr)
          `LDT_ADDR_CTRL: begin
            func_ff <= data[`LDT_BIT_FUNC_HI:`LDT_BIT_FUNC_LO];
            readback_ff <= data[`LDT_BIT_READBACK];
            range_ff <= data[`LDT_BIT_RANGE];
            run_ff <= data[`LDT_BIT_RUN];
            // Fresh start restarts count and after-run phase
            if (data[`LDT_BIT_RUN] && !run_ff) begin
              count_ff <= {CNT_W{1'b0}};
              afterDone_ff <= 1'b0;
            end
          end
          `LDT_ADDR_AFTER_RUN: afterRun_ff <= putByte(afterRun_ff, data, 2'd0);
          `LDT_ADDR_AFTER_RUN + 6'h01: afterRun_ff <= putByte(afterRun_ff, data, 2'd1);
          `LDT_ADDR_AFTER_RUN + 6'h02: afterRun_ff <= putByte(afterRun_ff, data, 2'd2);
          `LDT_ADDR_WAKE + 6'h02: wakeVal_ff <= putByte(wakeVal_ff, data, 2'd0);
          `LDT_ADDR_WAKE + 6'h03: wakeVal_ff <= putByte(wakeVal_ff, data, 2'd1);
          `LDT_ADDR_WAKE + 6'h04: wakeVal_ff <= putByte(wakeVal_ff, data, 2'd2);
          default: ;
        endcase
      end else if (tick) begin
        count_ff <= countInc;
        // Count mirrored into wake register in silent mode
        if (func_ff == `LDT_FN_SILENT)
          wakeVal_ff <= countInc;
        case (func_ff)
          `LDT_FN_FLAG: if (hitAfter) begin
            flag_ff <= 1'b1;
            timerIrq <= 1'b1;
            afterDone_ff <= 1'b1;
          end
          `LDT_FN_OFF: if (hitAfter) begin
            enterLowPowerOff <= 1'b1;
            afterDone_ff <= 1'b1;
          end
          `LDT_FN_OFF_WAKE: begin
            if (!afterDone_ff && hitAfter) begin
              enterLowPowerOff <= 1'b1;
              afterDone_ff <= 1'b1;
            end else if (afterDone_ff && hitWake) begin
              wakeUp <= 1'b1;
              run_ff <= 1'b0;
            end
          end
          `LDT_FN_WAKE: if (hitWake) begin
            wakeUp <= 1'b1;
            run_ff <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  // Read answer: one cycle after a read frame; unmapped reads zero
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      readData <= 16'h0000;
      readValid <= 1'b0;
    end else begin
      readValid <= frameValid && !isWrite;
      if (frameValid && !isWrite) begin
        case (addr)
          `LDT_ADDR_CTRL: readData <= {8'h00, func_ff, readback_ff, active, range_ff, run_ff, flag_ff};
          `LDT_ADDR_AFTER_RUN: readData <= {8'h00, afterRun_ff[7:0]};
          `LDT_ADDR_AFTER_RUN + 6'h01: readData <= {8'h00, afterRun_ff[15:8]};
          `LDT_ADDR_AFTER_RUN + 6'h02: readData <= {8'h00, afterRun_ff[CNT_W-1:16]};
          `LDT_ADDR_WAKE + 6'h02: readData <= {8'h00, wakeView[7:0]};
          `LDT_ADDR_WAKE + 6'h03: readData <= {8'h00, wakeView[15:8]};
          `LDT_ADDR_WAKE + 6'h04: readData <= {8'h00, wakeView[CNT_W-1:16]};
          default: readData <= 16'h0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** test/ldt_long_timer_assertions.sv ***
`default_nettype none
module ldt_long_timer_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic frameValid,
  input wire logic [15:0] frameIn,
  input wire logic inLowPowerOff,
  input wire logic [15:0] readData,
  input wire logic readValid,
  input wire logic parityErr,
  input wire logic timerIrq,
  input wire logic enterLowPowerOff,
  input wire logic wakeUp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Frame kinds as taken at the port
  sequence sRead; frameValid && !frameIn[15]; endsequence
  sequence sWrGood; frameValid && frameIn[15] && (^frameIn); endsequence
  sequence sWrBad; frameValid && frameIn[15] && !(^frameIn); endsequence
  a_read_answer: assert property (sRead |=> readValid)
    else $error("read not answered");
  a_answer_cause: assert property (readValid |-> $past(frameValid && !frameIn[15]))
    else $error("stray read answer");
  a_read_upper: assert property (readValid |-> readData[15:8] == 8'h00)
    else $error("upper read byte set");
  a_parity_bad: assert property (sWrBad |=> parityErr)
    else $error("bad parity missed");
  a_parity_good: assert property (sWrGood |=> !parityErr)
    else $error("good write refused");
  a_irq_single: assert property (timerIrq |=> !timerIrq)
    else $error("irq too long");
  a_off_single: assert property (enterLowPowerOff |=> !enterLowPowerOff)
    else $error("off request too long");
  a_wake_single: assert property (wakeUp |=> !wakeUp)
    else $error("wake too long");
endmodule
bind ldt_long_timer ldt_long_timer_assertions ldt_long_timer_assertions_i (.clk_sys(clk_sys), .rst(rst),
  .frameValid(frameValid), .frameIn(frameIn), .inLowPowerOff(inLowPowerOff), .readData(readData),
  .readValid(readValid), .parityErr(parityErr), .timerIrq(timerIrq), .enterLowPowerOff(enterLowPowerOff),
  .wakeUp(wakeUp));
`default_nettype wire

// *** test/ldt_mcu_model.sv ***
`default_nettype none
module ldt_mcu_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic wr,
  input wire logic bad,
  input wire logic [5:0] addr,
  input wire logic [7:0] data,
  output var logic frameValid,
  output var logic [15:0] frameIn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial frameValid = 1'b0;
  initial frameIn = 16'h0000;
  // Odd parity over the write frame; idle lines toggle so no stale frame survives
  always @(posedge clk_sys) begin
    frameValid <= go;
    if (!go) frameIn <= ~frameIn;
    else if (wr) frameIn <= {1'b1, addr, (~^{1'b1, addr, data}) ^ bad, data};
    else frameIn <= {1'b0, addr, 9'h000};
  end
endmodule
`default_nettype wire

// *** test/ldt_long_timer_bench.sv ***
`default_nettype none
module ldt_long_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst = 1, go = 0, wr = 0, bad = 0, holdOff = 0, offSt = 0;
  logic [5:0] addr = 6'h00;
  logic [7:0] data = 8'h00;
  wire logic frameValid, readValid, parityErr, timerIrq, enterLowPowerOff, wakeUp;
  wire logic [15:0] frameIn, readData;
  wire logic [2:0] ev = {wakeUp, enterLowPowerOff, timerIrq};
  int failures = 0, checked = 0, cyc = 0, seed = 20004, tStart = 0;
  int n[3];
  int t[3];
  ldt_mcu_model ldt_mcu_model_i (.clk_sys(clk_sys), .go(go), .wr(wr), .bad(bad), .addr(addr), .data(data),
    .frameValid(frameValid), .frameIn(frameIn));
  ldt_long_timer #(.CAL_LEN(4), .SEC_LEN(8)) ldt_long_timer_i (.clk_sys(clk_sys), .rst(rst),
    .frameValid(frameValid), .frameIn(frameIn), .inLowPowerOff(offSt | holdOff), .readData(readData),
    .readValid(readValid), .parityErr(parityErr), .timerIrq(timerIrq), .enterLowPowerOff(enterLowPowerOff),
    .wakeUp(wakeUp));
  initial forever #4 clk_sys = ~clk_sys;
  // Event log; the system side follows the power requests
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 3; k++) if (ev[k]) begin
      n[k] <= n[k] + 1;
      t[k] <= cyc;
    end
    if (rst) offSt <= 1'b0;
    else if (enterLowPowerOff) offSt <= 1'b1;
    else if (wakeUp) offSt <= 1'b0;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One frame; answer looked at in its single valid cycle
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d, input logic b,
      output logic [15:0] q);
    @(posedge clk_sys);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    data <= d;
    bad <= b;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
    q = readData;
    chk("readValid", 16'(readValid), 16'(!w));
    chk("parityErr", 16'(parityErr), 16'(w & b));
  endtask
  // Program targets, start, then compare event counts and timing with the expected values
  task automatic runFn(input logic [7:0] ctl, input int ar, input int wk, input logic off, input int len,
      input int e0, input int e1, input int e2, input int ek);
    int b[3];
    int tg;
    logic [15:0] q;
    holdOff <= off;
    xfer(1, 6'h06, 8'h00, 0, q);
    xfer(1, 6'h07, ar[7:0], 0, q);
    xfer(1, 6'h0a, wk[7:0], 0, q);
    b = n;
    tStart = cyc + 2;
    xfer(1, 6'h06, ctl, 0, q);
    repeat ((ar + wk + 4) * len) @(posedge clk_sys);
    tg = (ek == 2) ? wk : ar;
    chk("irqCount", 16'(n[0] - b[0]), 16'(e0));
    chk("offCount", 16'(n[1] - b[1]), 16'(e1));
    chk("wakeCount", 16'(n[2] - b[2]), 16'(e2));
    if (ek >= 0) chk("eventTime", 16'((t[ek] - tStart - tg * len) inside {[-1:3]}), 16'h0001);
  endtask
  task automatic end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    end_of_test();
  end
  initial begin
    logic [15:0] q;
    logic [15:0] q2;
    int ar;
    int c0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    xfer(0, 6'h06, 8'h00, 0, q);
    chk("ctrlReset", q, 16'h0000);
    xfer(1, 6'h06, 8'h02, 1, q);
    xfer(0, 6'h06, 8'h00, 0, q);
    chk("ctrlBadPar", q, 16'h0000);
    xfer(0, 6'h3f, 8'h00, 0, q);
    chk("unmapped", q, 16'h0000);
    ar = 3 + ($unsigned($random(seed)) % 4);
    for (int r = 0; r < 2; r++) begin
      runFn({5'h00, r[0], 2'b10}, ar, ar + 2, 0, r ? 8 : 4, 1, 0, 0, 0);
      xfer(0, 6'h06, 8'h00, 0, q);
      chk("flagSet", 16'(q[0]), 16'h0001);
      xfer(0, 6'h06, 8'h00, 0, q);
      chk("flagClear", 16'(q[0]), 16'h0000);
    end
    xfer(0, 6'h0a, 8'h00, 0, q);
    chk("wakeProg", q, 16'(ar + 2));
    runFn(8'h22, ar, ar + 2, 0, 4, 0, 1, 0, 1);
    runFn(8'h42, ar, ar + 3, 0, 4, 0, 1, 1, 2);
    runFn(8'h62, ar, ar + 1, 1, 4, 0, 0, 1, 2);
    runFn(8'h92, ar, 40, 1, 4, 0, 0, 0, -1);
    xfer(1, 6'h06, 8'h90, 0, q);
    c0 = cyc;
    xfer(0, 6'h0a, 8'h00, 0, q);
    chk("liveCount", 16'((int'(q) - (c0 - tStart) / 4) inside {[-2:1]}), 16'h0001);
    // Silent mode leaves the count mirrored in the wake register
    xfer(1, 6'h06, 8'h80, 0, q2);
    xfer(0, 6'h0a, 8'h00, 0, q2);
    chk("silentStore", q2, q);
    for (int c = 5; c < 8; c++) runFn({c[2:0], 5'h02}, ar, ar + 1, 1, 4, 0, 0, 0, -1);
    xfer(1, 6'h06, 8'h06, 0, q);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    xfer(0, 6'h06, 8'h00, 0, q);
    chk("ctrlReset2", q, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
